// ==== hpp_pkg.sv ====
// shared constants, types and decode functions for the host parallel port
`default_nettype none

package hpp_pkg;

  localparam int unsigned HPP_DW       = 16;
  localparam int unsigned HPP_BW       = 8;
  localparam int unsigned HPP_AW       = 3;
  localparam int unsigned HPP_SEL_FLAG = 2;
  localparam int unsigned HPP_SEL_DATA = 1;
  localparam int unsigned HPP_SEL_BYTE = 0;
  localparam logic [1:0]  HPP_CFG_WAIT = 2'h3;

  typedef enum logic [2:0] {
    HPP_CPU_SPLIT = 3'h0,
    HPP_CPU_DUAL  = 3'h1,
    HPP_CPU_RNW   = 3'h2
  } hpp_cpu_type;

  typedef enum logic [1:0] {
    HPP_PORT_CMD  = 2'h0,
    HPP_PORT_DATA = 2'h1,
    HPP_PORT_FLAG = 2'h2
  } hpp_port_type;

  typedef struct packed {
    logic [2:0] cpu_type;
    logic       mux_n;
    logic       irq_high;
    logic       big_endian;
    logic       narrow;
  } hpp_cfg_type;

  // every strap pin has a pull-up, so an open pin reads high
  localparam hpp_cfg_type HPP_CFG_RESET = '{cpu_type: 3'h7, mux_n: 1'b1, irq_high: 1'b1,
                                           big_endian: 1'b1, narrow: 1'b1};

  typedef struct packed {
    logic rd;
    logic wr;
    logic latch;
  } hpp_strobe_type;

  typedef struct packed {
    logic              is_cmd;
    logic [HPP_DW-1:0] word;
  } hpp_entry_type;

  typedef struct packed {
    logic              cs_n;
    logic [HPP_AW-1:0] addr;
    logic [HPP_DW-1:0] data;
    logic              rd_lo_n;
    logic              rd_hi_n;
    logic              wr_lo_n;
    logic              wr_hi_n;
    logic [2:0]        cpu_type;
    logic              mux;
    logic              pol;
    logic              endian;
    logic              size;
  } hpp_pins_type;

  function automatic hpp_port_type hpp_port(input logic [HPP_AW-1:0] sel);
    if (sel[HPP_SEL_FLAG]) begin
      return HPP_PORT_FLAG;
    end else if (sel[HPP_SEL_DATA]) begin
      return HPP_PORT_DATA;
    end else begin
      return HPP_PORT_CMD;
    end
  endfunction

  function automatic logic [HPP_DW-1:0] hpp_swap(input logic [HPP_DW-1:0] w, input logic en);
    return en ? {w[HPP_BW-1:0], w[HPP_DW-1:HPP_BW]} : w;
  endfunction

  // read, write and address-latch meaning of the four strobes per cpu type
  function automatic hpp_strobe_type hpp_strobes(input logic [2:0] cpu, input logic rd0_n,
                                                 input logic rd1_n, input logic wr0_n,
                                                 input logic wr1_n);
    hpp_strobe_type s;
    s = '0;
    case (cpu)
      HPP_CPU_DUAL: begin
        s.rd    = ~rd0_n | ~rd1_n;
        s.wr    = ~wr0_n | ~wr1_n;
        s.latch = rd0_n & rd1_n & wr0_n & wr1_n;
      end
      HPP_CPU_RNW: begin
        s.rd    = ~rd0_n & wr0_n;
        s.wr    = ~rd0_n & ~wr0_n;
        s.latch = ~rd1_n;
      end
      default: begin
        s.rd    = ~rd0_n;
        s.wr    = ~wr0_n;
        s.latch = ~rd1_n;
      end
    endcase
    return s;
  endfunction

endpackage

`default_nettype wire

// ==== hpp_sync.sv ====
// two-flop synchroniser for the host pins and straps
`timescale 1ns/1ps
`default_nettype none

module hpp_sync #(
  parameter int unsigned WIDTH = 31
) (
  input  wire logic             mclk,  // core clock
  input  wire logic             rst_n, // async reset, active low
  input  wire logic [WIDTH-1:0] d,     // asynchronous pin levels
  output logic      [WIDTH-1:0] q      // synchronised levels
);

  logic [WIDTH-1:0] meta;

  if (WIDTH < 1) begin : g_bad_width
    $error("hpp_sync: WIDTH must be at least 1");
  end

  // idle at the pulled-up level so nothing looks active out of reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '1;
      q    <= '1;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

`default_nettype wire

// ==== hpp_fifo.sv ====
// small fifo between the host write side and the core
`timescale 1ns/1ps
`default_nettype none

module hpp_fifo #(
  parameter int unsigned WIDTH = 17,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             mclk,      // core clock
  input  wire logic             rst_n,     // async reset, active low
  input  wire logic [WIDTH-1:0] in_data,   // word to store
  input  wire logic             in_valid,  // store request
  output logic                  in_ready,  // room for a word
  output logic      [WIDTH-1:0] out_data,  // oldest word
  output logic                  out_valid, // oldest word present
  input  wire logic             out_ready  // consumer takes the word
);

  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_ptr;
  logic [PW:0]      rd_ptr;
  logic             push;
  logic             pop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("hpp_fifo: DEPTH must be a power of two of at least 2");
  end

  assign in_ready  = !((wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data  = mem[rd_ptr[PW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ==== hpp_port.sv ====
// host parallel port: strap capture, port decode, byte lanes, swap, irq pin
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - accesses are honoured only while chip select is low; its rise ends a strobe.
// - select 00x command/status, 01x data, 1xx flag port.
// - in 8-bit mode lowest select bit picks upper or lower byte.
// - 8-bit mode uses low data lines only, upper never driven.
// - irq raised for pending causes, flag port reads which are pending.
// - irq active low when polarity strap low, active high otherwise.
// - mux, polarity, endian and size straps captured at reset, then used.
// - mux strap low means multiplexed bus, high means separate buses.
// - multiplexed mode latches low three data lines as port select.
// - latching control line depends on selected cpu type.
// - open mux strap reads high, giving separate bus operation.
// - big endian swaps bytes on command/status and data ports.
// - size strap low selects 16-bit bus, high selects 8-bit bus.
// - read and write strobes interpreted per captured cpu type field.
// - three cpu type straps pick the emulated host bus protocol.

module hpp_port
  import hpp_pkg::*;
#(
  parameter int unsigned BUF_DEPTH = 2
) (
  input  wire logic              mclk,               // core clock, 100 MHz
  input  wire logic              rst_n,              // async reset, active low
  input  wire logic              port_select_n,      // host chip select
  input  wire logic [HPP_AW-1:0] port_addr,          // host port select lines
  input  wire logic              read_strobe_lo_n,   // host read strobe 0
  input  wire logic              read_strobe_hi_n,   // host read strobe 1
  input  wire logic              write_strobe_lo_n,  // host write strobe 0
  input  wire logic              write_strobe_hi_n,  // host write strobe 1
  input  wire logic [HPP_DW-1:0] port_data_in,       // data pin levels
  output logic      [HPP_DW-1:0] port_data_out,      // data pin drive value
  output logic      [HPP_DW-1:0] port_data_oe,       // data pin enables
  output logic                   host_irq_out,       // irq pin drive value
  output logic                   host_irq_oe,        // irq pin enable
  input  wire logic [2:0]        cpu_type_strap,     // cpu type straps
  input  wire logic              bus_mux_strap,      // low: multiplexed bus
  input  wire logic              irq_polarity_strap, // low: irq active low
  input  wire logic              byte_order_strap,   // high: big endian
  input  wire logic              bus_size_strap,     // high: 8-bit bus
  output hpp_cfg_type            port_config_reg,    // captured straps
  output logic                   cfg_ready,          // straps captured
  output hpp_entry_type          wr_entry,           // command or data word
  output logic                   wr_valid,           // wr_entry present
  input  wire logic              wr_ready,           // core takes wr_entry
  output logic                   wr_overrun,         // write lost, buffer full
  input  wire logic [HPP_DW-1:0] status_word,        // status port contents
  input  wire logic [HPP_DW-1:0] rd_word,            // next data port word
  input  wire logic              rd_valid,           // rd_word present
  output logic                   rd_pop,             // rd_word consumed
  input  wire logic [HPP_DW-1:0] flags,              // pending causes
  output logic                   flag_clr_valid,     // host wrote flag port
  output logic      [HPP_DW-1:0] flag_clr_word       // word written to flag port
);

  if (BUF_DEPTH != 2) begin : g_bad_depth
    $error("hpp_port: BUF_DEPTH must be 2");
  end

  hpp_pins_type   pins_raw;
  hpp_pins_type   pins;
  hpp_cfg_type    cfg;
  hpp_strobe_type stb;
  hpp_port_type   port;
  hpp_port_type   wport;
  hpp_entry_type  push_entry;
  logic [1:0]              cfg_wait;
  logic [HPP_AW-1:0]       sel_lat;
  logic [HPP_AW-1:0]       sel;
  logic [HPP_AW-1:0]       wsel_q;
  logic [HPP_DW-1:0]       wdata_q;
  logic [HPP_DW-1:0]       rd_hold;
  logic [HPP_DW-1:0]       next_word;
  logic [HPP_DW-1:0]       next_rdata;
  logic [HPP_DW-1:0]       wword;
  logic [HPP_BW-1:0]       wr_hold_lo;
  logic                    sel_cs;
  logic                    rd_act;
  logic                    wr_act;
  logic                    rd_q;
  logic                    wr_q;
  logic                    rd_start;
  logic                    wr_end;
  logic                    byte_hi;
  logic                    wbyte_hi;
  logic                    commit;
  logic                    push_valid;
  logic                    push_ready;
  logic                    data_oe;

  assign pins_raw = '{cs_n: port_select_n, addr: port_addr, data: port_data_in,
                      rd_lo_n: read_strobe_lo_n, rd_hi_n: read_strobe_hi_n,
                      wr_lo_n: write_strobe_lo_n, wr_hi_n: write_strobe_hi_n,
                      cpu_type: cpu_type_strap, mux: bus_mux_strap, pol: irq_polarity_strap,
                      endian: byte_order_strap, size: bus_size_strap};

  hpp_sync #(
    .WIDTH ($bits(hpp_pins_type))
  ) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (pins_raw),
    .q     (pins)
  );

  // strap capture: pull-up defaults until the sync pipe is filled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_wait  <= 2'h0;
      cfg_ready <= 1'b0;
      cfg       <= HPP_CFG_RESET;
    end else if (!cfg_ready) begin
      cfg_wait <= cfg_wait + 2'h1;
      if (cfg_wait == HPP_CFG_WAIT) begin
        cfg_ready <= 1'b1;
        cfg       <= '{cpu_type: pins.cpu_type, mux_n: pins.mux, irq_high: pins.pol,
                       big_endian: pins.endian, narrow: pins.size};
      end
    end
  end

  assign port_config_reg = cfg;

  assign stb = hpp_strobes(cfg.cpu_type, pins.rd_lo_n, pins.rd_hi_n, pins.wr_lo_n,
                           pins.wr_hi_n);

  assign sel_cs = cfg_ready & ~pins.cs_n;
  assign rd_act = sel_cs & stb.rd;
  assign wr_act = sel_cs & stb.wr;

  // address phase latch from the low data lines
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_lat <= '0;
    end else if (sel_cs && stb.latch && !cfg.mux_n) begin
      sel_lat <= pins.data[HPP_AW-1:0];
    end
  end

  assign sel  = cfg.mux_n ? pins.addr : sel_lat;
  assign port = hpp_port(sel);
  // byte lane only counts on the 8-bit bus
  assign byte_hi = cfg.narrow & sel[HPP_SEL_BYTE];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      rd_q <= rd_act;
      wr_q <= wr_act;
    end
  end

  assign rd_start = rd_act & ~rd_q;
  assign wr_end   = wr_q & ~wr_act;

  // read word selection; high data byte comes from the word held at the low read
  always_comb begin
    next_word = status_word;
    case (port)
      HPP_PORT_FLAG: next_word = flags;
      HPP_PORT_DATA: next_word = byte_hi ? rd_hold : rd_word;
      default:       next_word = status_word;
    endcase
  end

  // swap on command/status and data only
  always_comb begin
    next_rdata = hpp_swap(next_word, cfg.big_endian && port != HPP_PORT_FLAG);
    if (cfg.narrow) begin
      next_rdata = {{HPP_BW{1'b0}},
                    byte_hi ? next_rdata[HPP_DW-1:HPP_BW] : next_rdata[HPP_BW-1:0]};
    end
  end

  assign rd_pop = rd_start & rd_valid & (port == HPP_PORT_DATA) & ~byte_hi;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port_data_out <= '0;
      rd_hold       <= '0;
    end else if (rd_start) begin
      port_data_out <= next_rdata;
      if (rd_pop) begin
        rd_hold <= rd_word;
      end
    end
  end

  // drive from one cycle after a selected read starts until one cycle after it ends
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      data_oe <= 1'b0;
    end else begin
      data_oe <= rd_act;
    end
  end

  // upper lane stays released on the 8-bit bus
  assign port_data_oe = {{HPP_BW{data_oe & ~cfg.narrow}}, {HPP_BW{data_oe}}};

  // write capture during the strobe, acted on at its trailing edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wdata_q <= '0;
      wsel_q  <= '0;
    end else if (wr_act) begin
      wdata_q <= pins.data;
      wsel_q  <= sel;
    end
  end

  assign wport    = hpp_port(wsel_q);
  assign wbyte_hi = cfg.narrow & wsel_q[HPP_SEL_BYTE];
  // low byte waits, high byte completes the word
  assign commit   = wr_end & (~cfg.narrow | wbyte_hi);
  assign wword    = cfg.narrow ? {wdata_q[HPP_BW-1:0], wr_hold_lo} : wdata_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_hold_lo <= '0;
    end else if (wr_end && cfg.narrow && !wbyte_hi) begin
      wr_hold_lo <= wdata_q[HPP_BW-1:0];
    end
  end

  // swap on command and data words
  assign push_entry = '{is_cmd: wport == HPP_PORT_CMD,
                        word: hpp_swap(wword, cfg.big_endian)};
  assign push_valid = commit & (wport != HPP_PORT_FLAG);

  hpp_fifo #(
    .WIDTH ($bits(hpp_entry_type)),
    .DEPTH (BUF_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_data   (push_entry),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .out_data  (wr_entry),
    .out_valid (wr_valid),
    .out_ready (wr_ready)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_overrun     <= 1'b0;
      flag_clr_valid <= 1'b0;
      flag_clr_word  <= '0;
    end else begin
      wr_overrun     <= push_valid & ~push_ready;
      flag_clr_valid <= commit & (wport == HPP_PORT_FLAG);
      if (commit && wport == HPP_PORT_FLAG) begin
        flag_clr_word <= wword;
      end
    end
  end

  // irq pin: active level per strap, released when idle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      host_irq_out <= 1'b0;
      host_irq_oe  <= 1'b0;
    end else begin
      host_irq_out <= cfg.irq_high;
      host_irq_oe  <= cfg_ready & (|flags);
    end
  end

  a_cs_read: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(data_oe) |-> $past(!pins.cs_n))
    else $error("data driven without chip select");

  a_upper_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg.narrow |-> port_data_oe[HPP_DW-1:HPP_BW] == '0)
    else $error("upper data lane driven on 8-bit bus");

  a_oe_release: assert property (@(posedge mclk) disable iff (!rst_n)
    (!rd_act ##1 !rd_act) |-> !data_oe)
    else $error("data lines driven outside a read");

  a_irq_raise: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg_ready && (|flags)) |=> host_irq_oe)
    else $error("pending cause did not drive irq");

  a_irq_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    !(|flags) |=> !host_irq_oe)
    else $error("irq driven with nothing pending");

  a_irq_level: assert property (@(posedge mclk) disable iff (!rst_n)
    host_irq_oe |-> host_irq_out == port_config_reg.irq_high)
    else $error("irq active level wrong");

  a_cfg_frozen: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg_ready |=> cfg_ready && $stable(cfg))
    else $error("captured straps changed");

  a_mux_latch: assert property (@(posedge mclk) disable iff (!rst_n)
    (!cfg.mux_n && sel_cs && stb.latch) |=> sel_lat == $past(pins.data[HPP_AW-1:0]))
    else $error("multiplexed select not latched");

  a_flag_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_start && port == HPP_PORT_FLAG && !cfg.narrow) |=> port_data_out == $past(flags))
    else $error("flag port read wrong");

  a_status_swap: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_start && port == HPP_PORT_CMD && !cfg.narrow && cfg.big_endian)
      |=> port_data_out == {$past(status_word[HPP_BW-1:0]),
                            $past(status_word[HPP_DW-1:HPP_BW])})
    else $error("status bytes not swapped");

endmodule

`default_nettype wire

// ==== hpp_host_model.sv ====
// host cpu bus model for the parallel port pins
`timescale 1ns/1ps
`default_nettype none

module hpp_host_model (
  input  wire logic        mclk,  // core clock
  input  wire logic [2:0]  cpu,   // strapped cpu type
  input  wire logic        muxed, // select rides on data lines
  input  wire logic [15:0] d_out, // device drive value
  input  wire logic [15:0] d_oe,  // device drive enables
  output logic             sel_n, // chip select
  output logic [2:0]       addr,  // port select lines
  output logic             rlo_n, // read strobe 0
  output logic             rhi_n, // read strobe 1
  output logic             wlo_n, // write strobe 0
  output logic             whi_n, // write strobe 1
  output logic [15:0]      d_in   // resolved data pin level
);
  logic        drv;
  logic [15:0] val;

  // pull-ups hold undriven lines high
  assign d_in = (d_oe & d_out) | (~d_oe & (drv ? val : 16'hFFFF));

  initial begin
    {sel_n, rlo_n, rhi_n, wlo_n, whi_n, addr} = 8'hFF;
    drv = 1'b0;
    val = 16'h0000;
  end

  task automatic access(input bit wr, input bit cs_hi, input logic [2:0] a,
                        input logic [15:0] d, output logic [15:0] q, output logic [15:0] oe);
    @(posedge mclk);
    #1;
    sel_n = cs_hi;
    addr = muxed ? ~a : a;
    drv = 1'b1;
    val = muxed ? {13'h0000, a} : d;
    if (muxed) begin
      // type 1 latches while all four strobes are idle, others on strobe 1
      rhi_n = (cpu == 3'h1);
      repeat (4) @(posedge mclk);
      #1;
      rhi_n = 1'b1;
    end
    wlo_n = (cpu == 3'h2) ? ~wr : 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    val = d;
    drv = wr;
    if (cpu == 3'h2) begin
      rlo_n = 1'b0;
    end else if (cpu == 3'h1) begin
      {rhi_n, whi_n} = wr ? 2'h2 : 2'h1;
    end else begin
      {rlo_n, wlo_n} = wr ? 2'h2 : 2'h1;
    end
    repeat (6) @(posedge mclk);
    #1;
    q = d_in;
    oe = d_oe;
    {rlo_n, rhi_n, wlo_n, whi_n} = 4'hF;
    @(posedge mclk);
    #1;
    sel_n = 1'b1;
    addr = 3'h7;
    drv = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask
endmodule

`default_nettype wire

// ==== host_parallel_port_select_tb_top.sv ====
// self-checking bench: host model and reference values against the port
`timescale 1ns/1ps
`default_nettype none

module host_parallel_port_select_tb_top;
  import hpp_pkg::*;

  logic          mclk, rst_n, sel_n, rlo_n, rhi_n, wlo_n, whi_n;
  logic [2:0]    cpu, addr;
  logic          mux_n, pol, endian, size, irq_out, irq_oe, cfg_ready;
  logic          wr_valid, wr_ready, wr_overrun, rd_valid, rd_pop, clr_valid;
  logic [15:0]   din, dout, doe, status_word, rd_word, flags, clr_word, q, oe;
  hpp_cfg_type   cfg;
  hpp_entry_type wr_entry;
  hpp_entry_type exp_q[$];
  int            n_errors, samples_checked, n_pop, n_clr, n_ovr, ovr_exp, seed;

  hpp_port i_hpp_port (
    .mclk(mclk), .rst_n(rst_n), .port_select_n(sel_n), .port_addr(addr),
    .read_strobe_lo_n(rlo_n), .read_strobe_hi_n(rhi_n), .write_strobe_lo_n(wlo_n),
    .write_strobe_hi_n(whi_n), .port_data_in(din), .port_data_out(dout),
    .port_data_oe(doe), .host_irq_out(irq_out), .host_irq_oe(irq_oe),
    .cpu_type_strap(cpu), .bus_mux_strap(mux_n), .irq_polarity_strap(pol),
    .byte_order_strap(endian), .bus_size_strap(size), .port_config_reg(cfg),
    .cfg_ready(cfg_ready), .wr_entry(wr_entry), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_overrun(wr_overrun), .status_word(status_word), .rd_word(rd_word),
    .rd_valid(rd_valid), .rd_pop(rd_pop), .flags(flags), .flag_clr_valid(clr_valid),
    .flag_clr_word(clr_word)
  );

  hpp_host_model i_hpp_host_model (
    .mclk(mclk), .cpu(cpu), .muxed(~mux_n), .d_out(dout), .d_oe(doe), .sel_n(sel_n),
    .addr(addr), .rlo_n(rlo_n), .rhi_n(rhi_n), .wlo_n(wlo_n), .whi_n(whi_n), .d_in(din)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // one-cycle pulses counted away from the update edge
  always @(negedge mclk) begin
    n_pop += int'(rd_pop === 1'b1);
    n_clr += int'(clr_valid === 1'b1);
    n_ovr += int'(wr_overrun === 1'b1);
  end

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic step();
    @(posedge mclk);
    #1;
  endtask

  task automatic wait_for(ref logic s);
    int k;
    k = 0;
    while (s !== 1'b1) begin
      step();
      k++;
      if (k > 20) begin
        check(32'(s), 32'h1);
        finish_test();
      end
    end
  endtask

  function automatic logic [15:0] swp(input logic [15:0] w, input logic en);
    return en ? {w[7:0], w[15:8]} : w;
  endfunction

  task automatic acc(input bit w, input bit h, input logic [2:0] a, input logic [15:0] d);
    i_hpp_host_model.access(w, h, a, d, q, oe);
  endtask

  task automatic wr_pins(input logic [2:0] a, input logic [15:0] w);
    if (size) begin
      acc(1'b1, 1'b0, a, {8'hFF, w[7:0]});
      acc(1'b1, 1'b0, a | 3'h1, {8'hFF, w[15:8]});
    end else begin
      acc(1'b1, 1'b0, a, w);
    end
  endtask

  task automatic wr_word(input logic [2:0] a, input logic [15:0] w);
    wr_pins(a, w);
    if (exp_q.size() < 2) begin
      exp_q.push_back({~a[1], swp(w, endian)});
    end else begin
      ovr_exp++;
    end
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [15:0] x);
    logic [15:0] y;
    y = a[HPP_SEL_FLAG] ? x : swp(x, endian);
    if (size) begin
      acc(1'b0, 1'b0, a, 16'h0000);
      check(32'(q[7:0]), 32'(y[7:0]));
      check(32'(oe), 32'h00FF);
      acc(1'b0, 1'b0, a | 3'h1, 16'h0000);
      check(32'(q[7:0]), 32'(y[15:8]));
    end else begin
      acc(1'b0, 1'b0, a, 16'h0000);
      check(32'(q), 32'(y));
      check(32'(oe), 32'hFFFF);
    end
    check(32'(doe), 32'h0000);
  endtask

  task automatic drain();
    hpp_entry_type e;
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      wait_for(wr_valid);
      check(32'(wr_entry), 32'(e));
      wr_ready = 1'b1;
      step();
      wr_ready = 1'b0;
    end
  endtask

  task automatic run_cfg(input int c);
    logic [15:0] w;
    int          p;
    step();
    cpu = (c == 8) ? 3'h7 : 3'(c % 3);
    {pol, endian, size} = 3'(c);
    mux_n = (c < 9);
    status_word = 16'($random(seed));
    rd_word = 16'($random(seed));
    flags = 16'h0000;
    rd_valid = 1'b1;
    rst_n = 1'b0;
    repeat (2) step();
    rst_n = 1'b1;
    wait_for(cfg_ready);
    check(32'(cfg), 32'({cpu, mux_n, pol, endian, size}));
    repeat (2) step();
    check(32'(irq_oe), 32'h0);
    flags = 16'($random(seed)) | 16'h0001;
    repeat (3) step();
    check(32'({irq_oe, irq_out}), 32'({1'b1, pol}));
    rd_chk(3'h6, flags);
    for (int i = 0; i < 3; i++) begin
      wr_word(3'(2 * (i % 2)), 16'($random(seed)));
    end
    drain();
    check(32'(n_ovr), 32'(ovr_exp));
    rd_chk(3'h0, status_word);
    p = n_pop;
    rd_chk(3'h2, rd_word);
    check(32'(n_pop - p), 32'h1);
    rd_valid = 1'b0;
    rd_chk(3'h2, rd_word);
    check(32'(n_pop - p), 32'h1);
    w = 16'($random(seed));
    p = n_clr;
    wr_pins(3'h4, w);
    check(32'(n_clr - p), 32'h1);
    check(32'(clr_word), 32'(w));
    // a lone high byte on the 8-bit bus would complete a word if select were ignored
    acc(1'b1, 1'b1, 3'(size), w);
    check(32'(wr_valid), 32'h0);
    acc(1'b0, 1'b1, 3'h2, w);
    check(32'(oe), 32'h0000);
  endtask

  initial begin
    seed = 45;
    rst_n = 1'b0;
    wr_ready = 1'b0;
    rd_valid = 1'b1;
    {cpu, mux_n, pol, endian, size} = 7'h7F;
    status_word = 16'h0000;
    rd_word = 16'h0000;
    flags = 16'h0000;
    for (int c = 0; c < 12; c++) begin
      run_cfg(c);
    end
    finish_test();
  end
endmodule

`default_nettype wire
